// ---- design/cdrs_top.sv ----
// clock divider, reset synchroniser and ready synchroniser with apb control
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1: selected source divided by three, one-third high
// R2: clear input stops the divide counter
// R3: far side syncs clear to source externally
// R4: strap picks oscillator or external source
// R5: oscillator always presented on its output
// R6: peripheral clock is half, fifty percent
// R7: reset request sampled on processor falling edge
// R8: each ready counts only while qualifier low
// R9: single-master systems tie qualifiers low
// R10: two-stage: rising ready via two flops
// R11: two-stage: falling ready straight to flop two
// R12: single-stage: flop one bypassed, falling edge
// R13: depth select may change every bus cycle
// R14: devices meet setup on unsynchronised edges
// R15: counters held while clear high, resume after
// R16: request low active, reset output high active
// R17: ready is or of qualified inputs
module cdrs_top
    import cdrs_pkg::*;
(
    input wire logic pclk,                              // system clock, 250 MHz
    input wire logic presetn,                           // asynchronous block reset, low active
    input wire logic psel,                              // apb select
    input wire logic penable,                           // apb enable
    input wire logic pwrite,                            // apb direction
    input wire logic [cdrs_pkg::CDRS_ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata,                     // apb write data
    output logic [31:0] prdata,                         // apb read data
    output logic pready,                                // apb ready
    output logic pslverr,                               // apb error on unmapped address
    input wire logic xtal_in,                           // oscillator signal
    input wire logic external_freq_in,                  // external frequency input
    input wire logic freq_select,                       // strap: 1 external, 0 oscillator
    input wire logic clock_sync_clear,                  // counter clear, high active
    input wire logic reset_request_n,                   // reset request, low active
    input wire logic bus_ready_in_a,                    // bus ready a
    input wire logic bus_ready_in_b,                    // bus ready b
    input wire logic ready_qualifier_a_n,               // qualifier a, low active
    input wire logic ready_qualifier_b_n,               // qualifier b, low active
    input wire logic sync_depth_select,                 // 1 single stage, 0 two stage
    output logic oscillator_out,                        // buffered oscillator
    output logic proc_clk,                              // processor clock
    output logic periph_clk,                            // peripheral clock
    output logic proc_reset,                            // processor reset, high active
    output logic ready_out                              // synchronised ready
);
    import cdrs_pkg::*;

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    logic [CDRS_NSYNC-1:0] meta_reg;     // first synchroniser stage, read only by stage two
    logic [CDRS_NSYNC-1:0] sync_reg;     // second synchroniser stage
    logic [CDRS_NSYNC-1:0] sync_next;    // pin word fed to the chain
    logic src_prev_reg, src_prev_next;   // last sampled source level
    logic src_sel_reg, src_sel_next;     // latched strap
    logic [1:0] strap_cnt_reg, strap_cnt_next; // wait before strap latch
    cdrs_div_t div_reg, div_next;        // divide-by-three phase
    logic proc_reg, proc_next;           // processor clock flop
    logic peri_reg, peri_next;           // peripheral clock flop
    logic prst_reg, prst_next;           // processor reset flop
    logic bus_ready_in_a_reg, bus_ready_in_a_next;           // ready flop one, rising edge
    logic bus_ready_in_b_reg, bus_ready_in_b_next;           // ready flop two, falling edge
    logic osc_reg, osc_next;             // oscillator output flop
    logic hold_reg, hold_next;           // software counter hold
    logic [31:0] prdata_reg, prdata_next; // read data flop
    logic pready_reg, pready_next;       // apb ready flop
    logic pslverr_reg, pslverr_next;     // apb error flop

    // ------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------
    logic src_now;                       // selected source level
    logic src_edge;                      // rising edge of selected source
    logic hold_all;                      // counters held by pin or software
    logic rise_ev;                       // processor clock about to rise
    logic fall_ev;                       // processor clock about to fall
    logic qual_rdy;                      // combined qualified ready
    logic acc;                           // apb access phase awaiting answer
    logic hit_ctrl;                      // address decodes to control
    logic hit_stat;                      // address decodes to status

    // pins gathered into one word for the two-flop chain
    assign sync_next = {sync_depth_select, ready_qualifier_b_n, ready_qualifier_a_n,
                        bus_ready_in_b, bus_ready_in_a, reset_request_n,
                        clock_sync_clear, freq_select, external_freq_in, xtal_in};

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // the source is sampled in pclk, so it must stay below a quarter of 250 MHz;
    // edges are counted rather than clocking off the pin, which keeps one domain
    always_comb begin
        src_now = src_sel_reg ? sync_reg[CDRS_S_EFI] : sync_reg[CDRS_S_XTAL]; // R4
        src_edge = src_now & ~src_prev_reg;
        hold_all = sync_reg[CDRS_S_CLR] | hold_reg; // R15
        rise_ev = ~hold_all & src_edge & (div_reg == DIV_LO2);
        fall_ev = ~hold_all & src_edge & (div_reg == DIV_HI);
        qual_rdy = (sync_reg[CDRS_S_RDYA] & ~sync_reg[CDRS_S_QA])
                 | (sync_reg[CDRS_S_RDYB] & ~sync_reg[CDRS_S_QB]); // R8 R17
        src_prev_next = src_now;
        osc_next = sync_reg[CDRS_S_XTAL]; // R5
        // strap is static: caught once, a few cycles after reset release
        strap_cnt_next = strap_cnt_reg;
        src_sel_next = src_sel_reg;
        if (strap_cnt_reg != CDRS_STRAP_WAIT) begin
            strap_cnt_next = strap_cnt_reg + 2'h1;
            src_sel_next = sync_reg[CDRS_S_STRAP]; // R4
        end
        // divide-by-three: one high phase, two low phases
        div_next = div_reg;
        if (hold_all) begin
            div_next = DIV_LO2; // R2 R15
        end else if (src_edge) begin
            unique case (div_reg)
                DIV_HI: div_next = DIV_LO1; // R1
                DIV_LO1: div_next = DIV_LO2;
                DIV_LO2: div_next = DIV_HI;
                default: div_next = DIV_LO2; // two-bit code has one illegal value
            endcase
        end
        proc_next = (div_next == DIV_HI); // R1
        // peripheral clock toggles at each processor falling edge
        peri_next = peri_reg;
        if (hold_all) begin
            peri_next = 1'b0; // R15
        end else if (fall_ev) begin
            peri_next = ~peri_reg; // R6
        end
        // reset request taken at the processor falling edge, polarity inverted
        prst_next = prst_reg;
        if (fall_ev) begin
            prst_next = ~sync_reg[CDRS_S_RES]; // R7 R16
        end
        // ready flop one samples on the rising processor edge
        bus_ready_in_a_next = bus_ready_in_a_reg;
        if (rise_ev) begin
            bus_ready_in_a_next = qual_rdy; // R10
        end
        // ready flop two on the falling edge; depth read fresh each time
        bus_ready_in_b_next = bus_ready_in_b_reg;
        if (fall_ev) begin
            if (sync_reg[CDRS_S_DEPTH]) begin
                bus_ready_in_b_next = qual_rdy; // R12 R13
            end else begin
                bus_ready_in_b_next = bus_ready_in_a_reg & qual_rdy; // R10 R11
            end
        end
        // apb slave: answer in the second access cycle from flops
        acc = psel & penable & ~pready_reg;
        hit_ctrl = (paddr == CDRS_CTRL_OFS);
        hit_stat = (paddr == CDRS_STAT_OFS);
        pready_next = acc;
        pslverr_next = acc & ~hit_ctrl & ~hit_stat;
        prdata_next = 32'h0000_0000;
        hold_next = hold_reg;
        // a write lands at the edge where the master samples pready high, not before
        if (psel & penable & pready_reg & pwrite & hit_ctrl) begin
            hold_next = pwdata[CDRS_CTRL_HOLD_BIT];
        end
        if (acc & ~pwrite) begin
            if (hit_ctrl) begin
                prdata_next[CDRS_CTRL_HOLD_BIT] = hold_reg;
            end else if (hit_stat) begin
                prdata_next[CDRS_STAT_PROC_BIT] = proc_reg;
                prdata_next[CDRS_STAT_PERI_BIT] = peri_reg;
                prdata_next[CDRS_STAT_RST_BIT] = prst_reg;
                prdata_next[CDRS_STAT_RDY_BIT] = bus_ready_in_b_reg;
                prdata_next[CDRS_STAT_SRC_BIT] = src_sel_reg;
                prdata_next[CDRS_STAT_HOLD_BIT] = hold_all;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // everything in one domain; asynchronous reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
            src_prev_reg <= 1'b0;
            src_sel_reg <= 1'b0;
            strap_cnt_reg <= 2'h0;
            div_reg <= DIV_LO2;
            proc_reg <= 1'b0;
            peri_reg <= 1'b0;
            prst_reg <= CDRS_PRST_RST;
            bus_ready_in_a_reg <= 1'b0;
            bus_ready_in_b_reg <= 1'b0;
            osc_reg <= 1'b0;
            hold_reg <= CDRS_CTRL_HOLD_RST;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            meta_reg <= sync_next;
            sync_reg <= meta_reg;
            src_prev_reg <= src_prev_next;
            src_sel_reg <= src_sel_next;
            strap_cnt_reg <= strap_cnt_next;
            div_reg <= div_next;
            proc_reg <= proc_next;
            peri_reg <= peri_next;
            prst_reg <= prst_next;
            bus_ready_in_a_reg <= bus_ready_in_a_next;
            bus_ready_in_b_reg <= bus_ready_in_b_next;
            osc_reg <= osc_next;
            hold_reg <= hold_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // outputs straight from flops
    assign oscillator_out = osc_reg;
    assign proc_clk = proc_reg;
    assign periph_clk = peri_reg;
    assign proc_reset = prst_reg;
    assign ready_out = bus_ready_in_b_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_two_stage_high;
        !sync_reg[CDRS_S_DEPTH] && fall_ev && bus_ready_in_a_reg && qual_rdy;
    endsequence

    sequence seq_two_stage_block;
        !sync_reg[CDRS_S_DEPTH] && fall_ev && !bus_ready_in_a_reg;
    endsequence

    // high phase lasts exactly until the next source edge
    AST_DUTY_HIGH: assert property (proc_clk && !src_edge && !hold_all |=> proc_clk) // R1
        else $error("processor clock dropped inside its high phase");

    AST_DUTY_END: assert property (proc_clk && (src_edge || hold_all) |=> !proc_clk) // R1
        else $error("processor clock high for more than one source period");

    AST_HOLD_LOW: assert property (hold_all |=> // R2
        !proc_clk && !periph_clk && div_reg == DIV_LO2)
        else $error("clocks not held low while counters cleared");

    AST_NO_EDGE_NO_STEP: assert property (!src_edge && !hold_all |=> $stable(div_reg)) // R4
        else $error("divider moved without a source edge");

    AST_OSC_FOLLOW: assert property (##1 oscillator_out == $past(sync_reg[CDRS_S_XTAL])) // R5
        else $error("oscillator output not following oscillator");

    AST_PERI_TOGGLE: assert property (fall_ev |=> periph_clk != $past(periph_clk)) // R6
        else $error("peripheral clock did not toggle at processor fall");

    AST_RESET_SYNC: assert property (fall_ev |=> proc_reset == !$past(sync_reg[CDRS_S_RES])) // R7
        else $error("reset output not taken at processor fall");

    AST_RESET_STILL: assert property (!fall_ev |=> $stable(proc_reset)) // R16
        else $error("reset output moved off the falling edge");

    AST_TWO_STAGE_UP: assert property (seq_two_stage_high |=> ready_out) // R10
        else $error("two-stage ready did not rise");

    AST_TWO_STAGE_HOLD: assert property (seq_two_stage_block |=> !ready_out) // R10
        else $error("two-stage ready rose without flop one");

    AST_FALL_DIRECT: assert property (fall_ev && !qual_rdy |=> !ready_out) // R11
        else $error("falling ready not passed straight through");

    AST_ONE_STAGE: assert property (fall_ev && sync_reg[CDRS_S_DEPTH] |=> // R12
        ready_out == $past(qual_rdy))
        else $error("single-stage ready not sampled at fall");

    AST_READY_STILL: assert property (!fall_ev |=> $stable(ready_out)) // R13
        else $error("ready output moved off the falling edge");

    AST_QUALIFY: assert property (rise_ev && sync_reg[CDRS_S_QA] && sync_reg[CDRS_S_QB] |=> // R8
        !bus_ready_in_a_reg)
        else $error("unqualified ready accepted");

    AST_PERI_STILL: assert property (!fall_ev && !hold_all |=> $stable(periph_clk)) // R6
        else $error("peripheral clock moved off the processor fall");

    // strap is static once latched, so later pin changes are ignored
    AST_STRAP_KEEP: assert property (strap_cnt_reg == CDRS_STRAP_WAIT |=> // R4
        $stable(src_sel_reg))
        else $error("source select changed after it was latched");

endmodule
`default_nettype wire

// ---- design/cdrs_pkg.sv ----
// package of constants shared by the clock divider and ready synchroniser
package cdrs_pkg;

    // ------------------------------------------------------------
    // register map, byte addresses on the apb bus
    // ------------------------------------------------------------
    localparam logic [11:0] CDRS_CTRL_OFS = 12'h000;   // control word
    localparam logic [11:0] CDRS_STAT_OFS = 12'h004;   // live status word
    localparam int CDRS_ADDR_W = 12;                   // decoded address bits

    // ------------------------------------------------------------
    // control field positions and reset values
    // ------------------------------------------------------------
    localparam int CDRS_CTRL_HOLD_BIT = 0;             // software hold of the counters
    localparam logic CDRS_CTRL_HOLD_RST = 1'b0;        // counters run after reset

    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int CDRS_STAT_PROC_BIT = 0;             // processor clock level
    localparam int CDRS_STAT_PERI_BIT = 1;             // peripheral clock level
    localparam int CDRS_STAT_RST_BIT = 2;              // processor reset level
    localparam int CDRS_STAT_RDY_BIT = 3;              // ready output level
    localparam int CDRS_STAT_SRC_BIT = 4;              // latched source select
    localparam int CDRS_STAT_HOLD_BIT = 5;             // counters held now

    // ------------------------------------------------------------
    // pin synchroniser lanes
    // ------------------------------------------------------------
    localparam int CDRS_NSYNC = 10;                    // number of synchronised pins
    localparam int CDRS_S_XTAL = 0;                    // oscillator input
    localparam int CDRS_S_EFI = 1;                     // external frequency input
    localparam int CDRS_S_STRAP = 2;                   // source select strap
    localparam int CDRS_S_CLR = 3;                     // clock sync clear
    localparam int CDRS_S_RES = 4;                     // reset request, low active
    localparam int CDRS_S_RDYA = 5;                    // bus ready a
    localparam int CDRS_S_RDYB = 6;                    // bus ready b
    localparam int CDRS_S_QA = 7;                      // qualifier a, low active
    localparam int CDRS_S_QB = 8;                      // qualifier b, low active
    localparam int CDRS_S_DEPTH = 9;                   // sync depth select

    // ------------------------------------------------------------
    // reset value of processor reset output and strap latch delay
    // ------------------------------------------------------------
    localparam logic CDRS_PRST_RST = 1'b1;             // processor held in reset
    localparam logic [1:0] CDRS_STRAP_WAIT = 2'h3;     // cycles before strap is latched

    // phases of the divide-by-three counter
    typedef enum logic [1:0] {
        DIV_HI,
        DIV_LO1,
        DIV_LO2
    } cdrs_div_t;

endpackage

// ---- dv/cdrs_partner.sv ----
// far-side model: clock sources, clear synchroniser and bus ready devices
`timescale 1ns/100ps
`default_nettype none
module cdrs_partner (
    input wire logic pclk,          // bench clock
    input wire logic clear_req,     // bench asks for a clock alignment
    input wire logic rdy_a_req,     // device a has finished its transfer
    input wire logic rdy_b_req,     // device b has finished its transfer
    output logic xtal_in,           // crystal source, six pclk period
    output logic external_freq_in,  // external source, eight pclk period
    output logic clock_sync_clear,  // clear, aligned to the external source
    output logic bus_ready_in_a,    // ready of device a
    output logic bus_ready_in_b     // ready of device b
);
    logic [2:0] efi_cnt = 3'h0;  // external source divider
    logic [2:0] xtl_cnt = 3'h0;  // crystal source divider, counts 0..5
    logic [1:0] clr_sync = 2'h0; // two flops clocked by the external source
    // -------------------------------------------------------------
    // sources
    // -------------------------------------------------------------
    // the two sources differ in period so the divider output shows which one it uses
    always_ff @(posedge pclk) begin
        efi_cnt <= efi_cnt + 3'h1;
        xtl_cnt <= (xtl_cnt == 3'h5) ? 3'h0 : xtl_cnt + 3'h1;
    end
    assign external_freq_in = efi_cnt[2];
    assign xtal_in = (xtl_cnt < 3'h3);
    // -------------------------------------------------------------
    // clear alignment and ready devices
    // -------------------------------------------------------------
    // clear is retimed to the external source outside the block
    always_ff @(posedge external_freq_in) begin
        clr_sync <= {clr_sync[0], clear_req};
    end
    assign clock_sync_clear = clr_sync[1];
    // synchronous devices: ready launched from the system clock, setup met
    always_ff @(posedge pclk) begin
        bus_ready_in_a <= rdy_a_req;
        bus_ready_in_b <= rdy_b_req;
    end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the clock divider and ready synchroniser
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import cdrs_pkg::*;
    logic pclk = 1'b0;               // 250 MHz system clock
    logic presetn = 1'b0;            // bench reset, low active
    logic psel = 1'b0;               // apb select
    logic penable = 1'b0;            // apb enable
    logic pwrite = 1'b0;             // apb direction
    logic [11:0] paddr = 12'h000;    // apb address
    logic [31:0] pwdata = 32'h0;     // apb write data
    logic [31:0] prdata;             // apb read data
    logic pready;                    // apb ready
    logic pslverr;                   // apb error
    logic xtal_in;                   // crystal source
    logic external_freq_in;          // external source
    logic freq_select = 1'b1;        // strap: external source
    logic clock_sync_clear;          // aligned clear
    logic reset_request_n = 1'b1;    // reset request, low active
    logic bus_ready_in_a;            // ready a
    logic bus_ready_in_b;            // ready b
    logic qa_n = 1'b0;               // qualifier a, tied low in single-master use
    logic qb_n = 1'b0;               // qualifier b, tied low in single-master use
    logic sync_depth_select = 1'b1;  // open pin reads as single stage
    logic oscillator_out;            // buffered oscillator
    logic proc_clk;                  // processor clock
    logic periph_clk;                // peripheral clock
    logic proc_reset;                // processor reset
    logic ready_out;                 // synchronised ready
    logic clear_req = 1'b0;          // clear request to the partner
    logic rdy_a_req = 1'b0;          // ready request to device a
    logic rdy_b_req = 1'b0;          // ready request to device b
    int errors = 0;                  // mismatches seen
    int n_tests = 0;                 // comparisons made
    wire [2:0] clks = {oscillator_out, periph_clk, proc_clk}; // measured clocks
    always #2 pclk = ~pclk;
    // -------------------------------------------------------------
    // instances
    // -------------------------------------------------------------
    cdrs_partner u_partner (.pclk(pclk), .clear_req(clear_req), .rdy_a_req(rdy_a_req),
        .rdy_b_req(rdy_b_req), .xtal_in(xtal_in), .external_freq_in(external_freq_in),
        .clock_sync_clear(clock_sync_clear), .bus_ready_in_a(bus_ready_in_a),
        .bus_ready_in_b(bus_ready_in_b));
    cdrs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xtal_in(xtal_in), .external_freq_in(external_freq_in),
        .freq_select(freq_select), .clock_sync_clear(clock_sync_clear),
        .reset_request_n(reset_request_n), .bus_ready_in_a(bus_ready_in_a),
        .bus_ready_in_b(bus_ready_in_b), .ready_qualifier_a_n(qa_n),
        .ready_qualifier_b_n(qb_n), .sync_depth_select(sync_depth_select),
        .oscillator_out(oscillator_out), .proc_clk(proc_clk), .periph_clk(periph_clk),
        .proc_reset(proc_reset), .ready_out(ready_out));
    // -------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                            output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // high and low run lengths of one clock, in pclk cycles
    task automatic measure(input int b, output int hi, output int lo);
        int n;
        n = 0;
        hi = 0;
        lo = 0;
        while (clks[b] !== 1'b0 && n < 200) begin @(posedge pclk); n++; end
        while (clks[b] !== 1'b1 && n < 200) begin @(posedge pclk); n++; end
        while (clks[b] === 1'b1 && n < 200) begin @(posedge pclk); hi++; n++; end
        while (clks[b] === 1'b0 && n < 200) begin @(posedge pclk); lo++; n++; end
    endtask
    // cycles until a watched level is reached, bounded
    task automatic wait_lvl(input int b, input logic lvl, output int n);
        n = 0;
        while ((b == 3 ? ready_out : clks[b]) !== lvl && n < 60) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic err;
        logic p;
        int hi;
        int lo;
        int n;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        check("proc_reset_rst", proc_reset, 32'h1);
        check("ready_rst", ready_out, 32'h0);
        apb_xfer(1'b0, CDRS_CTRL_OFS, 32'h0, rd, err);
        check("ctrl_rst", rd, {31'h0, CDRS_CTRL_HOLD_RST});
        apb_xfer(1'b0, 12'h008, 32'h0, rd, err);
        check("unmapped_err", {31'h0, err}, 32'h1);
        measure(0, hi, lo);
        check("proc_hi", hi, 32'h8);
        check("proc_lo", lo, 32'h10);
        measure(1, hi, lo);
        check("periph_hi", hi, 32'h18);
        check("periph_lo", lo, 32'h18);
        measure(2, hi, lo);
        check("osc_period", {hi[15:0], lo[15:0]}, 32'h00030003);
        // reset request: output must move only together with a proc_clk fall
        check("proc_reset_run", proc_reset, 32'h0);
        for (int v = 0; v < 2; v++) begin
            reset_request_n <= v[0];
            n = 0;
            do begin
                p = proc_clk;
                @(posedge pclk);
                n++;
            end while (proc_reset !== ~v[0] && n < 80);
            check("reset_edge", {p, proc_clk}, 32'h2);
            check("reset_level", proc_reset, {31'h0, ~v[0]});
        end
        // software hold is read back in status; pin clear freezes the divider
        apb_xfer(1'b1, CDRS_CTRL_OFS, 32'h1, rd, err);
        apb_xfer(1'b0, CDRS_CTRL_OFS, 32'h0, rd, err);
        check("ctrl_rw", rd, 32'h1);
        apb_xfer(1'b0, CDRS_STAT_OFS, 32'h0, rd, err);
        check("hold_stat", rd[CDRS_STAT_HOLD_BIT], 32'h1);
        apb_xfer(1'b1, CDRS_CTRL_OFS, 32'h0, rd, err);
        clear_req <= 1'b1;
        repeat (30) @(posedge pclk);
        hi = 0;
        repeat (48) begin
            @(posedge pclk);
            if (proc_clk !== 1'b0 || periph_clk !== 1'b0) hi++;
        end
        check("clear_frozen", hi, 32'h0);
        clear_req <= 1'b0;
        wait_lvl(0, 1'b1, n);
        check("clear_resume", {31'h0, n < 60}, 32'h1);
        // unqualified ready is ignored
        qa_n <= 1'b1;
        qb_n <= 1'b1;
        rdy_a_req <= 1'b1;
        rdy_b_req <= 1'b1;
        repeat (60) @(posedge pclk);
        check("unqualified", ready_out, 32'h0);
        // each depth and each lane; qualifier driven low just after a proc_clk rise
        for (int d = 0; d < 2; d++) begin
            for (int l = 0; l < 2; l++) begin
                sync_depth_select <= d[0];
                measure(0, hi, lo);
                wait_lvl(0, 1'b1, n);
                if (l == 0) qa_n <= 1'b0; else qb_n <= 1'b0;
                wait_lvl(3, 1'b1, n);
                p = (n < 16) == (d == 1) && n < 60;
                check("ready_rise", {31'h0, p}, 32'h1);
                wait_lvl(0, 1'b0, n);
                wait_lvl(0, 1'b1, n);
                qa_n <= 1'b1;
                qb_n <= 1'b1;
                wait_lvl(3, 1'b0, n);
                check("ready_fall", {31'h0, n < 16}, 32'h1);
            end
        end
        // second reset with the oscillator strapped: divider now runs from it
        freq_select <= 1'b0;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        check("proc_reset_rst2", proc_reset, 32'h1);
        measure(0, hi, lo);
        check("xtal_proc", {hi[15:0], lo[15:0]}, 32'h0006_000c);
        complete_run();
    end
    // hang guard, far beyond the thousand or so cycles the sequence needs
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("MISMATCH watchdog expected done seen hang");
        complete_run();
    end
endmodule
`default_nettype wire
